// ---- dv/adc_serial_read_sva.sv ----
// Purpose: Port checks for the converter serial read-out block.
// Assumes: ce_in high; host pins far slower than mclk_in.
// Notes: Pin-to-output latency gets a small window for the synchronisers.
`timescale 1ns/1ps
module adc_serial_read_sva
    import adc_read_pkg::*;
(
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic cs_n_in,
    input wire logic serial_out_lane0_out,
    input wire logic serial_out_lane1_out,
    input wire logic serial_out_lane2_out,
    input wire logic serial_out_lane3_out,
    input wire logic source_clock_strobe_out,
    input wire logic [7:0] input_protocol_ctrl_out,
    input wire logic [7:0] output_protocol_ctrl_out,
    input wire logic frame_active_out,
    input wire logic underrun_out
);
    logic [3:0] ln;
    assign ln = {serial_out_lane3_out, serial_out_lane2_out, serial_out_lane1_out,
        serial_out_lane0_out};
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    chk_strobe_low: assert property (
        output_protocol_ctrl_out[1:0] != LAUNCH_SRC |-> !source_clock_strobe_out)
        else $error("strobe high in legacy protocol");
    chk_lanes_idle: assert property (!frame_active_out |-> ln == 4'h0)
        else $error("lane driven outside frame");
    chk_frame_open: assert property ($fell(cs_n_in) |-> ##[2:5] frame_active_out)
        else $error("frame did not open");
    chk_frame_close: assert property ($rose(cs_n_in) |-> ##[2:5] !frame_active_out)
        else $error("frame did not close");
    chk_reset_ctrl: assert property ($rose(resetn_in) |->
        input_protocol_ctrl_out == 8'h00 && output_protocol_ctrl_out == 8'h00)
        else $error("control not default after reset");
    chk_single_lane: assert property (
        output_protocol_ctrl_out[3:2] < LANES_DUAL |-> ln[3:1] == 3'h0)
        else $error("extra lane active in single mode");
    chk_dual_lane: assert property (
        output_protocol_ctrl_out[3:2] == LANES_DUAL |-> ln[3:2] == 2'h0)
        else $error("upper lanes active in dual mode");
    chk_late_launch: assert property (
        $rose(frame_active_out) && input_protocol_ctrl_out[0] |-> !serial_out_lane0_out)
        else $error("bit launched before first clock edge");
    // The registers update as the frame closes, one cycle before the active flag drops.
    chk_ctrl_hold: assert property (frame_active_out ##1 frame_active_out ##1
        frame_active_out |-> $past(input_protocol_ctrl_out) == $past(input_protocol_ctrl_out, 2)
        && $past(output_protocol_ctrl_out) == $past(output_protocol_ctrl_out, 2))
        else $error("control changed inside a frame");
    cover property (source_clock_strobe_out);
    cover property ($rose(frame_active_out) && output_protocol_ctrl_out[3:2] == LANES_QUAD);
    cover property ($rose(frame_active_out) && input_protocol_ctrl_out[1:0] == CLK_HIGH_RISE);
    cover property (underrun_out);
endmodule // adc_serial_read_sva

bind adc_serial_read adc_serial_read_sva i_sva (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .cs_n_in(cs_n_in),
    .serial_out_lane0_out(serial_out_lane0_out), .serial_out_lane1_out(serial_out_lane1_out),
    .serial_out_lane2_out(serial_out_lane2_out), .serial_out_lane3_out(serial_out_lane3_out),
    .source_clock_strobe_out(source_clock_strobe_out),
    .input_protocol_ctrl_out(input_protocol_ctrl_out),
    .output_protocol_ctrl_out(output_protocol_ctrl_out),
    .frame_active_out(frame_active_out), .underrun_out(underrun_out)
);

// ---- dv/host_model.sv ----
// Purpose: Behavioural host that runs frames and samples the data lanes.
// Assumes: Serial clock period 48 ns, free of mclk_in.
// Notes: Lanes are sampled just before each clock edge of every cycle.
`timescale 1ns/1ps
module host_model (
    output logic cs_n_out,
    output logic sclk_out,
    output logic sdi_out,
    input wire logic [3:0] lanes_in
);
    logic [3:0] cap [32];
    logic [3:0] oth [32];
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        sdi_out = 1'b0;
    end
    task automatic xfer(input logic [1:0] m, input int n, input logic [31:0] tx);
        sclk_out = m[1];
        #100;
        cs_n_out = 1'b0;
        for (int i = 0; i < n; i++) begin
            if (!m[0]) sdi_out = tx[31-i];
            #24;
            if (!m[0]) cap[i] = lanes_in;
            else oth[i] = lanes_in;
            sclk_out = ~sclk_out;
            if (m[0]) sdi_out = tx[31-i];
            #24;
            if (!m[0]) oth[i] = lanes_in;
            else cap[i] = lanes_in;
            sclk_out = ~sclk_out;
        end
        #24;
        cs_n_out = 1'b1;
        // The released data line floats, so show the inverse rather than a held value.
        sdi_out = ~sdi_out;
        #100;
    endtask
endmodule // host_model

// ---- dv/tb_adc_serial_read.sv ----
// Purpose: Self-checking bench for the converter serial read-out block.
// Assumes: host_model makes the pins; words are pushed from here.
// Notes: Buffer stall, daisy chain, all clock modes and lane widths.
`timescale 1ns/1ps
module tb_adc_serial_read;
    import adc_read_pkg::*;
    logic mclk_in, resetn_in, conv_valid_in, conv_ready_out, fa, ur, strobe;
    logic cs_n, sclk, sdi;
    logic [21:0] conv_data_in;
    wire [3:0] ln;
    logic [7:0] in_ctrl, out_ctrl;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    int ur_cnt = 0;
    adc_serial_read i_dut (
        .mclk_in(mclk_in), .resetn_in(resetn_in), .ce_in(1'b1), .cs_n_in(cs_n),
        .sclk_in(sclk), .sdi_in(sdi), .conv_data_in(conv_data_in),
        .conv_valid_in(conv_valid_in), .conv_ready_out(conv_ready_out),
        .serial_out_lane0_out(ln[0]), .serial_out_lane1_out(ln[1]),
        .serial_out_lane2_out(ln[2]), .serial_out_lane3_out(ln[3]),
        .source_clock_strobe_out(strobe), .input_protocol_ctrl_out(in_ctrl),
        .output_protocol_ctrl_out(out_ctrl), .frame_active_out(fa), .underrun_out(ur)
    );
    host_model i_host (.cs_n_out(cs_n), .sclk_out(sclk), .sdi_out(sdi), .lanes_in(ln));
    initial begin
        mclk_in = 1'b0;
        forever #2 mclk_in = ~mclk_in;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    function automatic logic bitat(input logic [21:0] w, input int k);
        return (k >= 0 && k < 22) ? w[k] : 1'b0;
    endfunction
    task automatic push(input logic [21:0] w);
        @(posedge mclk_in) #1;
        conv_data_in = w;
        conv_valid_in = 1'b1;
        while (conv_ready_out !== 1'b1) @(posedge mclk_in) #1;
        @(posedge mclk_in) #1;
        conv_valid_in = 1'b0;
    endtask
    task automatic wr(input logic [1:0] m, input logic [9:0] a, input logic [7:0] d,
        input logic [3:0] op = CMD_WRITE);
        i_host.xfer(m, 22, {op, a, d, 10'h000});
    endtask
    // Late modes sample mid-cycle one group behind; early launch one group ahead.
    task automatic chk_word(input logic [21:0] w, input int l, input int n,
        input logic [1:0] m, input int e);
        int k;
        for (int i = 0; i < n; i++) begin
            for (int j = 0; j < l; j++) begin
                check(i_host.cap[i][j], bitat(w, 21 - i * l - j));
                k = m[0] ? 21 - (i - 1) * l - j : 21 - (i + e) * l - j;
                if (i > 0) check(i_host.oth[i][j], bitat(w, k));
            end
        end
    endtask
    task automatic t_reset();
        check(in_ctrl, 8'h00);
        check(out_ctrl, 8'h00);
        $display("t_reset done");
    endtask
    task automatic t_buffer();
        logic [21:0] w [3] = '{22'h2a5c3f, 22'h15a3c0, 22'h3ff001};
        push(w[0]);
        push(w[1]);
        fork
            push(w[2]);
        join_none
        repeat (6) @(posedge mclk_in);
        #1;
        check(conv_ready_out, 1'b0);
        for (int i = 0; i < 3; i++) begin
            i_host.xfer(2'h0, 22, 32'h0);
            chk_word(w[i], 1, 22, 2'h0, 0);
        end
        check(ur_cnt, 0);
        $display("t_buffer done");
    endtask
    task automatic t_daisy();
        logic [7:0] d = 8'hc5;
        push(22'h0f0f33);
        i_host.xfer(2'h0, 30, {d, 24'h0});
        chk_word(22'h0f0f33, 1, 22, 2'h0, 0);
        for (int k = 0; k < 8; k++) check(i_host.cap[22 + k][0], d[7 - k]);
        $display("t_daisy done");
    endtask
    task automatic t_modes();
        logic [1:0] p = 2'h0;
        wr(2'h0, OUTPUT_CTRL_ADDR, CHAIN_CTRL_EARLY);
        check(out_ctrl, 8'h01);
        check(ur_cnt, 1);
        for (int m = 0; m < 4; m++) begin
            wr(p, INPUT_CTRL_ADDR, 8'(m));
            p = 2'(m);
            check(in_ctrl, 8'(m));
            push(22'h3b2d3c + 22'(m));
            i_host.xfer(p, 22, 32'h0);
            chk_word(22'h3b2d3c + 22'(m), 1, 22, p, int'(!p[0]));
        end
        wr(p, INPUT_CTRL_ADDR, 8'h00);
        check(in_ctrl, 8'h00);
        $display("t_modes done");
    endtask
    task automatic t_lanes();
        logic [7:0] c [5] = '{8'h03, 8'h08, 8'h0c, 8'h09, 8'h0d};
        for (int i = 0; i < 5; i++) begin
            wr(2'h0, OUTPUT_CTRL_ADDR, c[i]);
            push(22'h2c96e1);
            i_host.xfer(2'h0, 14, 32'hffffffff);
            check(out_ctrl, c[i]);
            chk_word(22'h2c96e1, c[i][3] ? (c[i][2] ? 4 : 2) : 1, 14, 2'h0,
                int'(c[i][0]));
        end
        wr(2'h0, OUTPUT_CTRL_ADDR, 8'h0c, CMD_CLEAR);
        check(out_ctrl, 8'h01);
        wr(2'h0, OUTPUT_CTRL_ADDR, 8'h08, CMD_SET);
        check(out_ctrl, 8'h09);
        @(posedge mclk_in) #1 resetn_in = 1'b0;
        @(posedge mclk_in) #1 resetn_in = 1'b1;
        repeat (3) @(posedge mclk_in);
        #1;
        check(out_ctrl, 8'h00);
        $display("t_lanes done");
    endtask
    always @(posedge mclk_in) begin
        cyc++;
        if (ur === 1'b1) ur_cnt++;
        if (cyc == 40000) begin
            err_total++;
            test_done();
        end
    end
    initial begin
        resetn_in = 1'b0;
        conv_valid_in = 1'b0;
        conv_data_in = 22'h000000;
        repeat (10) @(posedge mclk_in);
        #1 resetn_in = 1'b1;
        repeat (5) @(posedge mclk_in);
        t_reset();
        t_buffer();
        t_daisy();
        t_modes();
        t_lanes();
        test_done();
    end
endmodule // tb_adc_serial_read

// ---- src/adc_read_pkg.sv ----
// Purpose: Shared constants for the converter serial read-out block.
// Assumes: 22-bit output word, 22-bit command frame, 8-bit control registers.
// Notes: Command opcodes and register addresses are local encodings.

package adc_read_pkg;

    // ------------------------------------------------------------------
    // Word sizes
    // ------------------------------------------------------------------
    localparam int DATA_BITS = 22;
    localparam int CMD_BITS = 22;
    localparam logic [4:0] CMD_MIN_CLOCKS = 5'd22;

    // ------------------------------------------------------------------
    // Input clock modes (polarity at frame start, capture edge)
    // ------------------------------------------------------------------
    localparam logic [1:0] CLK_LOW_RISE = 2'h0;
    localparam logic [1:0] CLK_LOW_FALL = 2'h1;
    localparam logic [1:0] CLK_HIGH_FALL = 2'h2;
    localparam logic [1:0] CLK_HIGH_RISE = 2'h3;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int LAUNCH_MODE_LSB = 0;
    localparam int LANE_COUNT_LSB = 2;
    localparam int INPUT_MODE_LSB = 0;
    localparam logic [1:0] LAUNCH_STD = 2'h0;
    localparam logic [1:0] LAUNCH_EARLY = 2'h1;
    localparam logic [1:0] LAUNCH_SRC = 2'h3;
    localparam logic [1:0] LANES_DUAL = 2'h2;
    localparam logic [1:0] LANES_QUAD = 2'h3;
    localparam logic [7:0] CHAIN_CTRL_STD = 8'h00;
    localparam logic [7:0] CHAIN_CTRL_EARLY = 8'h01;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] INPUT_CTRL_RST = 8'h00;
    localparam logic [7:0] OUTPUT_CTRL_RST = 8'h00;

    // ------------------------------------------------------------------
    // Command frame layout: opcode, address, data
    // ------------------------------------------------------------------
    localparam int CMD_OP_LSB = 18;
    localparam int CMD_ADDR_LSB = 8;
    localparam logic [3:0] CMD_WRITE = 4'h1;
    localparam logic [3:0] CMD_CLEAR = 4'h2;
    localparam logic [3:0] CMD_SET = 4'h3;
    localparam logic [9:0] INPUT_CTRL_ADDR = 10'h010;
    localparam logic [9:0] OUTPUT_CTRL_ADDR = 10'h011;

endpackage

// ---- src/adc_serial_read.sv ----
// Purpose: Serial read-out and configuration slave of a 22-bit converter.
// Assumes: Host drives chip select, serial clock and serial input pins.
// Notes: Pins are oversampled by mclk_in; serial clock must be much slower.

`timescale 1ns/1ps

module adc_serial_read
    import adc_read_pkg::*;
#(
    parameter int WORD_BITS = DATA_BITS
) (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic ce_in,
    input wire logic cs_n_in,
    input wire logic sclk_in,
    input wire logic sdi_in,
    input wire logic [WORD_BITS-1:0] conv_data_in,
    input wire logic conv_valid_in,
    output logic conv_ready_out,
    output logic serial_out_lane0_out,
    output logic serial_out_lane1_out,
    output logic serial_out_lane2_out,
    output logic serial_out_lane3_out,
    output logic source_clock_strobe_out,
    output logic [7:0] input_protocol_ctrl_out,
    output logic [7:0] output_protocol_ctrl_out,
    output logic frame_active_out,
    output logic underrun_out
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    initial begin
        if (WORD_BITS != DATA_BITS) begin
            $error("adc_serial_read serves a 22-bit output word only");
        end
    end

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // Modes 00 and 11 capture on the rising serial clock edge.
    function automatic logic captures_on_rise(input logic [1:0] mode);
        return (mode == CLK_LOW_RISE) || (mode == CLK_HIGH_RISE);
    endfunction

    // Shift the output word by the active lane count, filling at the bottom.
    function automatic logic [DATA_BITS-1:0] shift_word(
        input logic [DATA_BITS-1:0] word,
        input logic [1:0] lanes,
        input logic fill
    );
        logic [DATA_BITS-1:0] res;
        res = '0;
        case (lanes)
            LANES_DUAL: res = {word[DATA_BITS-3:0], 2'h0};
            LANES_QUAD: res = {word[DATA_BITS-5:0], 4'h0};
            default: res = {word[DATA_BITS-2:0], fill};
        endcase
        return res;
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------------
    logic [2:0] pins_s;
    logic cs_n_s, sclk_s, sdi_s;

    pin_sync #(
        .WIDTH(3),
        .RST_VAL(3'h7)
    ) u_pin_sync (
        .mclk_in(mclk_in),
        .resetn_in(resetn_in),
        .ce_in(ce_in),
        .async_in({cs_n_in, sclk_in, sdi_in}),
        .sync_out(pins_s)
    );

    assign cs_n_s = pins_s[2];
    assign sclk_s = pins_s[1];
    assign sdi_s = pins_s[0];

    logic cs_n_d_r, cs_n_d_nxt;
    logic sclk_d_r, sclk_d_nxt;
    logic frame_start, frame_end, sclk_rise, sclk_fall;

    always_comb begin
        cs_n_d_nxt = cs_n_s;
        sclk_d_nxt = sclk_s;
        frame_start = cs_n_d_r & ~cs_n_s;
        frame_end = ~cs_n_d_r & cs_n_s;
        sclk_rise = ~sclk_d_r & sclk_s;
        sclk_fall = sclk_d_r & ~sclk_s;
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cs_n_d_r <= 1'b1;
            sclk_d_r <= 1'b1;
        end else if (ce_in) begin
            cs_n_d_r <= cs_n_d_nxt;
            sclk_d_r <= sclk_d_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Converter word buffer
    // ------------------------------------------------------------------
    logic [DATA_BITS-1:0] head_data;
    logic head_valid;

    // A stall by the shifter keeps words here; the source sees ready fall.
    word_buffer #(
        .WIDTH(DATA_BITS)
    ) u_word_buffer (
        .mclk_in(mclk_in),
        .resetn_in(resetn_in),
        .ce_in(ce_in),
        .s_data_in(conv_data_in),
        .s_valid_in(conv_valid_in),
        .s_ready_out(conv_ready_out),
        .m_data_out(head_data),
        .m_valid_out(head_valid),
        .m_ready_in(frame_start)
    );

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    logic [7:0] in_ctrl_r, in_ctrl_nxt;
    logic [7:0] out_ctrl_r, out_ctrl_nxt;
    logic [1:0] clk_mode, launch_mode, lane_count;
    logic early, src_mode, daisy;

    always_comb begin
        clk_mode = in_ctrl_r[INPUT_MODE_LSB +: 2];
        launch_mode = out_ctrl_r[LAUNCH_MODE_LSB +: 2];
        lane_count = out_ctrl_r[LANE_COUNT_LSB +: 2];
        // Early launch only exists where the MSB already leaves at select fall.
        early = (launch_mode == LAUNCH_EARLY) && !clk_mode[0];
        src_mode = (launch_mode == LAUNCH_SRC);
        daisy = (out_ctrl_r == CHAIN_CTRL_STD) || (out_ctrl_r == CHAIN_CTRL_EARLY);
    end

    // ------------------------------------------------------------------
    // Frame state
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_FIRST,
        ST_SHIFT
    } frame_state_type;

    frame_state_type state_r, state_nxt;
    logic [DATA_BITS-1:0] shift_r, shift_nxt;
    logic [CMD_BITS-1:0] cmd_r, cmd_nxt;
    logic [4:0] bit_cnt_r, bit_cnt_nxt;
    logic sdi_cap_r, sdi_cap_nxt;
    logic in_frame, cap_edge, launch_edge, step_edge, fill_bit;
    logic underrun_nxt;

    always_comb begin
        state_nxt = state_r;
        shift_nxt = shift_r;
        cmd_nxt = cmd_r;
        bit_cnt_nxt = bit_cnt_r;
        sdi_cap_nxt = sdi_cap_r;
        underrun_nxt = 1'b0;
        in_frame = (state_r != ST_IDLE);
        // Modes 00/11 capture rising, 01/10 capture falling.
        cap_edge = in_frame && (captures_on_rise(clk_mode) ? sclk_rise : sclk_fall);
        launch_edge = in_frame && (captures_on_rise(clk_mode) ? sclk_fall : sclk_rise);
        if (src_mode) begin
            step_edge = in_frame && sclk_rise;
        end else if (early) begin
            step_edge = cap_edge;
        end else begin
            step_edge = launch_edge;
        end
        // With early launch the shift shares the capture edge, so take the pin now.
        fill_bit = daisy ? (early ? sdi_s : sdi_cap_r) : 1'b0;

        if (cap_edge) begin
            sdi_cap_nxt = sdi_s;
            cmd_nxt = {cmd_r[CMD_BITS-2:0], sdi_s};
            if (bit_cnt_r != CMD_MIN_CLOCKS) begin
                bit_cnt_nxt = bit_cnt_r + 5'd1;
            end
        end

        case (state_r)
            ST_IDLE: begin
                if (frame_start) begin
                    bit_cnt_nxt = 5'd0;
                    shift_nxt = head_valid ? head_data : '0;
                    underrun_nxt = !head_valid;
                    // Outside source-synchronous launch, modes 01/11 hold the MSB back until the first launch edge.
                    if (clk_mode[0] && !src_mode) begin
                        state_nxt = ST_WAIT_FIRST;
                    end else begin
                        state_nxt = ST_SHIFT;
                    end
                end
            end
            ST_WAIT_FIRST: begin
                if (frame_end) begin
                    state_nxt = ST_IDLE;
                end else if (launch_edge) begin
                    state_nxt = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (frame_end) begin
                    state_nxt = ST_IDLE;
                end else if (step_edge) begin
                    shift_nxt = shift_word(shift_r, lane_count, fill_bit);
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_r <= ST_IDLE;
            shift_r <= '0;
            cmd_r <= '0;
            bit_cnt_r <= 5'd0;
            sdi_cap_r <= 1'b0;
            underrun_out <= 1'b0;
        end else if (ce_in) begin
            state_r <= state_nxt;
            shift_r <= shift_nxt;
            cmd_r <= cmd_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            sdi_cap_r <= sdi_cap_nxt;
            underrun_out <= underrun_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Command decode at frame end
    // ------------------------------------------------------------------
    logic [3:0] cmd_op;
    logic [9:0] cmd_addr;
    logic [7:0] cmd_data;
    logic cmd_go;

    always_comb begin
        cmd_op = cmd_r[CMD_OP_LSB +: 4];
        cmd_addr = cmd_r[CMD_ADDR_LSB +: 10];
        cmd_data = cmd_r[7:0];
        // Short frames are reads only; the new setting counts from the next frame.
        cmd_go = (state_r != ST_IDLE) && frame_end && (bit_cnt_r == CMD_MIN_CLOCKS);
        in_ctrl_nxt = in_ctrl_r;
        out_ctrl_nxt = out_ctrl_r;
        if (cmd_go) begin
            case (cmd_op)
                CMD_WRITE: begin
                    if (cmd_addr == INPUT_CTRL_ADDR) begin
                        in_ctrl_nxt = cmd_data;
                    end
                    if (cmd_addr == OUTPUT_CTRL_ADDR) begin
                        out_ctrl_nxt = cmd_data;
                    end
                end
                CMD_CLEAR: begin
                    if (cmd_addr == INPUT_CTRL_ADDR) begin
                        in_ctrl_nxt = in_ctrl_r & ~cmd_data;
                    end
                    if (cmd_addr == OUTPUT_CTRL_ADDR) begin
                        out_ctrl_nxt = out_ctrl_r & ~cmd_data;
                    end
                end
                CMD_SET: begin
                    if (cmd_addr == INPUT_CTRL_ADDR) begin
                        in_ctrl_nxt = in_ctrl_r | cmd_data;
                    end
                    if (cmd_addr == OUTPUT_CTRL_ADDR) begin
                        out_ctrl_nxt = out_ctrl_r | cmd_data;
                    end
                end
                default: begin
                    in_ctrl_nxt = in_ctrl_r;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            in_ctrl_r <= INPUT_CTRL_RST;
            out_ctrl_r <= OUTPUT_CTRL_RST;
        end else if (ce_in) begin
            in_ctrl_r <= in_ctrl_nxt;
            out_ctrl_r <= out_ctrl_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Output pins
    // ------------------------------------------------------------------
    logic [3:0] lanes_nxt;
    logic [3:0] lanes_r;
    logic strobe_nxt, strobe_r;
    logic active_nxt, active_r;

    always_comb begin
        lanes_nxt = 4'h0;
        if (state_r == ST_SHIFT) begin
            case (lane_count)
                LANES_DUAL: lanes_nxt = {2'h0, shift_r[DATA_BITS-2], shift_r[DATA_BITS-1]};
                LANES_QUAD: lanes_nxt = {shift_r[DATA_BITS-4], shift_r[DATA_BITS-3],
                                         shift_r[DATA_BITS-2], shift_r[DATA_BITS-1]};
                default: lanes_nxt = {3'h0, shift_r[DATA_BITS-1]};
            endcase
        end
        // Only the source-synchronous entry echoes the host clock; legacy keeps it low.
        strobe_nxt = src_mode && (state_r != ST_IDLE) && sclk_s;
        active_nxt = (state_r != ST_IDLE);
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            lanes_r <= 4'h0;
            strobe_r <= 1'b0;
            active_r <= 1'b0;
        end else if (ce_in) begin
            lanes_r <= lanes_nxt;
            strobe_r <= strobe_nxt;
            active_r <= active_nxt;
        end
    end

    assign serial_out_lane0_out = lanes_r[0];
    assign serial_out_lane1_out = lanes_r[1];
    assign serial_out_lane2_out = lanes_r[2];
    assign serial_out_lane3_out = lanes_r[3];
    assign source_clock_strobe_out = strobe_r;
    assign input_protocol_ctrl_out = in_ctrl_r;
    assign output_protocol_ctrl_out = out_ctrl_r;
    assign frame_active_out = active_r;

endmodule // adc_serial_read

// ---- src/pin_sync.sv ----
// Purpose: Two-flop synchroniser for asynchronous pin inputs.
// Assumes: Each bit is an independent level.
// Notes: Only the second stage leaves this module.

`timescale 1ns/1ps

module pin_sync #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RST_VAL = '1
) (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic ce_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    initial begin
        if (WIDTH < 1) begin
            $error("pin_sync needs at least one bit");
        end
    end

    // The reset level is a parameter, so the asynchronous branch loads constants only.
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end else if (ce_in) begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;

endmodule // pin_sync

// ---- src/word_buffer.sv ----
// Purpose: Two-entry buffer for converter words ahead of the shifter.
// Assumes: Source and sink on the same clock.
// Notes: Ready toward the source is a register.

`timescale 1ns/1ps

module word_buffer #(
    parameter int WIDTH = 22
) (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic ce_in,
    input wire logic [WIDTH-1:0] s_data_in,
    input wire logic s_valid_in,
    output logic s_ready_out,
    output logic [WIDTH-1:0] m_data_out,
    output logic m_valid_out,
    input wire logic m_ready_in
);

    logic [WIDTH-1:0] slot0_r, slot0_nxt;
    logic [WIDTH-1:0] slot1_r, slot1_nxt;
    logic [1:0] count_r, count_nxt;
    logic ready_r, ready_nxt;
    logic push, pop;

    initial begin
        if (WIDTH < 1) begin
            $error("word_buffer needs a positive width");
        end
    end

    always_comb begin
        push = s_valid_in & ready_r;
        pop = m_ready_in & (count_r != 2'h0);
        slot0_nxt = slot0_r;
        slot1_nxt = slot1_r;
        count_nxt = count_r;
        if (pop) begin
            slot0_nxt = slot1_r;
        end
        if (push) begin
            if (count_r == 2'h0 || (count_r == 2'h1 && pop)) begin
                slot0_nxt = s_data_in;
            end else begin
                slot1_nxt = s_data_in;
            end
        end
        count_nxt = count_r + {1'b0, push} - {1'b0, pop};
        ready_nxt = (count_nxt != 2'h2);
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            slot0_r <= '0;
            slot1_r <= '0;
            count_r <= 2'h0;
            ready_r <= 1'b1;
        end else if (ce_in) begin
            slot0_r <= slot0_nxt;
            slot1_r <= slot1_nxt;
            count_r <= count_nxt;
            ready_r <= ready_nxt;
        end
    end

    assign s_ready_out = ready_r;
    assign m_data_out = slot0_r;
    assign m_valid_out = (count_r != 2'h0);

endmodule // word_buffer
